// *** bench/fdsf_host.sv ***
// Purpose: APB master standing in for the configuration host
// Assumes: slave answers within eight cycles
// Notes: one idle cycle between transfers
`timescale 1ns/1ps
`default_nettype none
module fdsf_host (
   input wire logic mclk,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata
);
   initial {psel, penable, pwrite, paddr, pwdata} = '0;
   // Request held until pready seen high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [32:0] q);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'h1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'h1 && n < 8);
      q = {pslverr, prdata};
      psel <= 1'h0;
      penable <= 1'h0;
      if (pready !== 1'h1) begin
         tb_top.bad_count++;
         tb_top.close_out();
      end
   endtask
endmodule // fdsf_host
`default_nettype wire

// *** bench/fdsf_monitor.sv ***
// Purpose: port assertions for the status flag bank
// Assumes: conditions show on the bytes three edges after the pins
// Notes: bound into fdsf_top at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module fdsf_monitor
   import fdsf_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire fdsf_cond_t cond,
   input wire logic [7:0] device_status_byte,
   input wire logic [7:0] extended_device_status_byte,
   input wire logic [7:0] diagnostic_status_zero,
   input wire logic [7:0] diagnostic_status_one
);
   fdsf_cond_t c1_ff, c2_ff, k_ff;
   logic [1:0] up_ff;
   logic ps_ff;
   wire logic ss = diagnostic_status_one[0];
   wire logic [7:0] ds = device_status_byte;
   wire logic [7:0] es = extended_device_status_byte;
   wire logic [7:0] d0 = diagnostic_status_zero;
   // Skip the sync fill and the edge after simulation ends
   wire logic live = up_ff == 2'h3 && !ss && !ps_ff;
   always_ff @(posedge mclk) begin
      c1_ff <= cond;
      c2_ff <= c1_ff;
      k_ff <= c2_ff;
      ps_ff <= ss;
   end
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) up_ff <= 2'h0;
      else if (up_ff != 2'h3) up_ff <= up_ff + 2'h1;
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);
   property p_dev;
      live |-> ds[7] == k_ff.hw_fault && ds[3:0] == {k_ff.loop_fixed, k_ff.loop_sat,
         k_ff.secondary_variable_oor, k_ff.primary_variable_oor};
   endproperty
   a_dev: assert property (p_dev) else $error("device byte wrong");
   property p_ext;
      live |-> es == {2'h0, k_ff.work_in_progress, k_ff.out_of_spec, k_ff.var_invalid, 1'h0, k_ff.var_alert, k_ff.maint_req};
   endproperty
   a_ext: assert property (p_ext) else $error("extended byte wrong");
   property p_diag0;
      live |-> d0 == {k_ff.write_protect, k_ff.elec_defect, k_ff.env_oor, 3'h0, k_ff.nvm_bad, k_ff.var_sim};
   endproperty
   a_diag0: assert property (p_diag0) else $error("diag zero wrong");
   property p_unused;
      (es & ~FDSF_EXT_USED) == 8'h00 && (d0 & ~FDSF_D0_USED) == 8'h00 && (diagnostic_status_one[7:1] == 7'h00);
   endproperty
   a_unused: assert property (p_unused) else $error("unused bit set");
   property p_more;
      live |-> ds[4] == (|{es, d0});
   endproperty
   a_more: assert property (p_more) else $error("more status wrong");
   property p_ssim;
      ss && ps_ff |-> ds[4] && $stable(es) && $stable(d0);
   endproperty
   a_ssim: assert property (p_ssim) else $error("simulated status moved");
   property p_cold;
      up_ff == 2'h0 || (up_ff == 2'h3 && !ss && $rose(k_ff.self_test)) |-> ds[5];
   endproperty
   a_cold: assert property (p_cold) else $error("cold start missing");
   property p_cfg;
      up_ff == 2'h3 && !ss && $rose(k_ff.cfg_write) |-> ds[6];
   endproperty
   a_cfg: assert property (p_cfg) else $error("config changed missing");
endmodule // fdsf_monitor
bind fdsf_top fdsf_monitor u_fdsf_monitor (.*);
`default_nettype wire

// *** bench/tb_top.sv ***
// Purpose: self-checking bench for the status flag bank
// Assumes: conditions settle three edges after a change
// Notes: host model drives the APB side
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import fdsf_pkg::*;
;
   logic mclk, nrst, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, device_status_byte, extended_device_status_byte;
   logic [7:0] diagnostic_status_zero, diagnostic_status_one;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb = 4'hF;
   logic [32:0] q;
   fdsf_cond_t cond = '0;
   int bad_count = 0;
   int check_count = 0;
   // One condition raised, {dev, ext, diag0, diag1}, bit 0 first
   logic [31:0] exp_tab [17] = '{32'h1000_8000, 32'h1000_4000, 32'h1000_2000, 32'h1000_0200, 32'h1000_0100,
      32'h1020_0000, 32'h1010_0000, 32'h1008_0000, 32'h1002_0000, 32'h1001_0000, 32'h0100_0000,
      32'h0200_0000, 32'h0400_0000, 32'h0800_0000, 32'h2000_0000, 32'h4000_0000, 32'h8000_0000};
   fdsf_top u_fdsf_top (.*);
   fdsf_host u_fdsf_host (.*);
   initial begin
      mclk = 1'h0;
      forever #4 mclk = ~mclk;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic close_out();
      if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
      u_fdsf_host.xfer(1'h0, a, 32'h0, q);
      chk("read data", e, q[31:0]);
      chk("pslverr", {31'h0, err}, {31'h0, q[32]});
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_fdsf_host.xfer(1'h1, a, d, q);
   endtask
   initial begin
      nrst = 1'h0;
      repeat (20) @(posedge mclk);
      nrst <= 1'h1;
      rd(FDSF_OFS_DEV, 32'h20, 1'h0);
      wr(FDSF_OFS_CTRL, 32'h3);
      for (int i = 0; i < 17; i++) begin
         cond <= fdsf_cond_t'(17'h1 << i);
         repeat (4) @(posedge mclk);
         for (int j = 0; j < 4; j++) rd(8'(j * 4), {24'h0, exp_tab[i][31 - 8 * j -: 8]}, 1'h0);
         cond <= '0;
         repeat (4) @(posedge mclk);
         rd(FDSF_OFS_DEV, (i == 14 || i == 15) ? {24'h0, exp_tab[i][31:24]} : 32'h0, 1'h0);
         wr(FDSF_OFS_CTRL, 32'h3);
      end
      wr(FDSF_OFS_SIM, 32'h0000_0081);
      wr(FDSF_OFS_CTRL, 32'h4);
      cond <= fdsf_cond_t'(17'h0_8200);
      repeat (4) @(posedge mclk);
      rd(FDSF_OFS_DEV, 32'h91, 1'h0);
      rd(FDSF_OFS_EXT, 32'h0, 1'h0);
      rd(FDSF_OFS_DIAG1, 32'h1, 1'h0);
      wr(FDSF_OFS_CTRL, 32'h0);
      rd(FDSF_OFS_EXT, 32'h1, 1'h0);
      wr(FDSF_OFS_DEV, 32'hFF);
      rd(FDSF_OFS_DEV, 32'h50, 1'h0);
      rd(8'h18, 32'h0, 1'h1);
      close_out();
   end
endmodule // tb_top
`default_nettype wire

// *** src/fdsf_pkg.sv ***
// Purpose: constants and types for the field device status flag bank
// Assumes: APB slave with 32-bit data, one word per register
// Notes: status bytes sit in the low eight bits of each word
package fdsf_pkg;
   // ********************
   // Register map
   // ********************
   localparam logic [7:0] FDSF_OFS_DEV = 8'h00;
   localparam logic [7:0] FDSF_OFS_EXT = 8'h04;
   localparam logic [7:0] FDSF_OFS_DIAG0 = 8'h08;
   localparam logic [7:0] FDSF_OFS_DIAG1 = 8'h0C;
   localparam logic [7:0] FDSF_OFS_CTRL = 8'h10;
   localparam logic [7:0] FDSF_OFS_SIM = 8'h14;
   // ********************
   // Device status bits
   // ********************
   localparam int FDSF_DS_MALF = 7;
   localparam int FDSF_DS_CFGCHG = 6;
   localparam int FDSF_DS_COLD = 5;
   localparam int FDSF_DS_MORE = 4;
   localparam int FDSF_DS_FIXED = 3;
   localparam int FDSF_DS_SAT = 2;
   localparam int FDSF_DS_SVOOL = 1;
   localparam int FDSF_DS_PVOOL = 0;
   // ********************
   // Extended and diagnostic bits
   // ********************
   localparam int FDSF_EX_MAINT = 0;
   localparam int FDSF_EX_ALERT = 1;
   localparam int FDSF_EX_FAIL = 3;
   localparam int FDSF_EX_OOSPEC = 4;
   localparam int FDSF_EX_FCHK = 5;
   localparam int FDSF_D0_VSIM = 0;
   localparam int FDSF_D0_NVM = 1;
   localparam int FDSF_D0_ENV = 5;
   localparam int FDSF_D0_ELEC = 6;
   localparam int FDSF_D0_LOCK = 7;
   localparam int FDSF_D1_SSIM = 0;
   // Control register: write 1 clears configuration-changed and cold start
   localparam int FDSF_CTRL_CLR_CFG = 0;
   localparam int FDSF_CTRL_CLR_COLD = 1;
   localparam int FDSF_CTRL_SSIM_EN = 2;
   // Bits that may ever be set in each byte
   localparam logic [7:0] FDSF_EXT_USED = 8'h3B;
   localparam logic [7:0] FDSF_D0_USED = 8'hE3;
   localparam logic [7:0] FDSF_D1_USED = 8'h01;
   localparam logic [7:0] FDSF_RST_BYTE = 8'h00;
   // Device byte after reset: cold start only
   localparam logic [7:0] FDSF_RST_DEV = 8'h20;
   localparam logic [31:0] FDSF_RST_WORD = 32'h0000_0000;

   // Condition inputs from the rest of the transmitter
   typedef struct packed {
      logic hw_fault;
      logic cfg_write;
      logic self_test;
      logic loop_fixed;
      logic loop_sat;
      logic secondary_variable_oor;
      logic primary_variable_oor;
      logic maint_req;
      logic var_alert;
      logic var_invalid;
      logic out_of_spec;
      logic work_in_progress;
      logic var_sim;
      logic nvm_bad;
      logic env_oor;
      logic elec_defect;
      logic write_protect;
   } fdsf_cond_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [7:0] dev;
      logic [7:0] ext;
      logic [7:0] diag0;
      logic [7:0] diag1;
      logic ssim_en;
      logic [7:0] sim_dev;
      logic [16:0] cond_meta;
      logic [16:0] cond_sync;
      logic [16:0] cond_last;
      logic [7:0] real_dev;
   } fdsf_state_t;
endpackage

// *** src/fdsf_top.sv ***
// Purpose: status flag bank of a field transmitter behind an APB slave
// Assumes: condition inputs are asynchronous levels; cfg_write and self_test are levels held at least two cycles
// Notes: one-cycle access, no wait states
// Function
// - Malfunction bit follows detected hardware error or failure.
// - Configuration changed bit sets on any configuration modification.
// - Configuration changed stays set until host reset action clears it.
// - Cold start bit sets after reset, self test or power cycle.
// - More status available set when any other status byte nonzero.
// - Loop current fixed bit follows fixed output mode.
// - Loop current saturated bit follows output outside range limits.
// - Secondary variable out of limits bit follows its condition.
// - Primary variable out of limits bit follows its condition.
// - Maintenance required bit in extended byte.
// - Variable alert bit in extended byte.
// - Failure bit when variables invalid through internal malfunction.
// - Out of specification bit when accuracy is endangered.
// - Function check bit while work makes variables invalid.
// - Variable simulation bit in diagnostic zero.
// - Nonvolatile memory defect bit in diagnostic zero.
// - Environmental out of range bit in diagnostic zero.
// - Electronic defect bit in diagnostic zero.
// - Configuration locked bit while write protected.
// - Status simulation bit; device byte shows simulated byte, extended and diagnostic zero held meanwhile.
`timescale 1ns/1ps
`default_nettype none
module fdsf_top
   import fdsf_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire fdsf_cond_t cond,
   output logic [7:0] device_status_byte,
   output logic [7:0] extended_device_status_byte,
   output logic [7:0] diagnostic_status_zero,
   output logic [7:0] diagnostic_status_one
);
   fdsf_state_t st_ff;
   fdsf_state_t nxt_st;
   fdsf_cond_t c;
   fdsf_cond_t c_prev;
   logic [7:0] live_dev;
   logic [7:0] live_ext;
   logic [7:0] live_d0;
   logic wr;
   logic rd;
   logic hit;

   // ********************
   // Next state
   // ********************
   always_comb begin
      nxt_st = st_ff;
      // Only the second and third stages are read by logic
      nxt_st.cond_meta = cond;
      nxt_st.cond_sync = st_ff.cond_meta;
      // Third stage is the delayed copy for edge detection
      nxt_st.cond_last = st_ff.cond_sync;
      c = fdsf_cond_t'(st_ff.cond_sync);
      c_prev = fdsf_cond_t'(st_ff.cond_last);
      wr = psel & penable & pwrite;
      rd = psel & penable & ~pwrite;
      hit = (paddr == FDSF_OFS_DEV) | (paddr == FDSF_OFS_EXT) | (paddr == FDSF_OFS_DIAG0) |
            (paddr == FDSF_OFS_DIAG1) | (paddr == FDSF_OFS_CTRL) | (paddr == FDSF_OFS_SIM);

      live_ext = FDSF_RST_BYTE;
      live_ext[FDSF_EX_MAINT] = c.maint_req;
      live_ext[FDSF_EX_ALERT] = c.var_alert;
      live_ext[FDSF_EX_FAIL] = c.var_invalid;
      live_ext[FDSF_EX_OOSPEC] = c.out_of_spec;
      live_ext[FDSF_EX_FCHK] = c.work_in_progress;
      live_ext = live_ext & FDSF_EXT_USED;

      live_d0 = FDSF_RST_BYTE;
      live_d0[FDSF_D0_VSIM] = c.var_sim;
      live_d0[FDSF_D0_NVM] = c.nvm_bad;
      live_d0[FDSF_D0_ENV] = c.env_oor;
      live_d0[FDSF_D0_ELEC] = c.elec_defect;
      live_d0[FDSF_D0_LOCK] = c.write_protect;
      live_d0 = live_d0 & FDSF_D0_USED;

      live_dev = st_ff.real_dev;
      live_dev[FDSF_DS_MALF] = c.hw_fault;
      live_dev[FDSF_DS_FIXED] = c.loop_fixed;
      live_dev[FDSF_DS_SAT] = c.loop_sat;
      live_dev[FDSF_DS_SVOOL] = c.secondary_variable_oor;
      live_dev[FDSF_DS_PVOOL] = c.primary_variable_oor;
      if (wr && paddr == FDSF_OFS_CTRL && pstrb[0] && pwdata[FDSF_CTRL_CLR_CFG]) begin
         live_dev[FDSF_DS_CFGCHG] = 1'b0;
      end
      if (wr && paddr == FDSF_OFS_CTRL && pstrb[0] && pwdata[FDSF_CTRL_CLR_COLD]) begin
         live_dev[FDSF_DS_COLD] = 1'b0;
      end
      if (c.cfg_write && !c_prev.cfg_write) begin
         live_dev[FDSF_DS_CFGCHG] = 1'b1;
      end
      if (c.self_test && !c_prev.self_test) begin
         live_dev[FDSF_DS_COLD] = 1'b1;
      end
      live_dev[FDSF_DS_MORE] = (|live_ext) | (|live_d0) | st_ff.ssim_en;

      if (wr && pstrb[0] && paddr == FDSF_OFS_CTRL) begin
         nxt_st.ssim_en = pwdata[FDSF_CTRL_SSIM_EN];
      end
      if (wr && pstrb[0] && paddr == FDSF_OFS_SIM) begin
         nxt_st.sim_dev = pwdata[7:0];
      end

      // Latched bits keep tracking while the host sees the simulated byte
      nxt_st.real_dev = live_dev;
      if (st_ff.ssim_en) begin
         nxt_st.dev = st_ff.sim_dev;
         nxt_st.dev[FDSF_DS_MORE] = 1'b1;
      end else begin
         nxt_st.dev = live_dev;
         nxt_st.ext = live_ext;
         nxt_st.diag0 = live_d0;
      end
      nxt_st.diag1 = {7'b000_0000, st_ff.ssim_en} & FDSF_D1_USED;

      nxt_st.pready = psel & ~penable;
      nxt_st.pslverr = psel & ~penable & ~hit;
      nxt_st.prdata = FDSF_RST_WORD;
      if (psel && !penable && !pwrite) begin
         case (paddr)
            FDSF_OFS_DEV: nxt_st.prdata = {24'h00_0000, st_ff.dev};
            FDSF_OFS_EXT: nxt_st.prdata = {24'h00_0000, st_ff.ext};
            FDSF_OFS_DIAG0: nxt_st.prdata = {24'h00_0000, st_ff.diag0};
            FDSF_OFS_DIAG1: nxt_st.prdata = {24'h00_0000, st_ff.diag1};
            FDSF_OFS_CTRL: nxt_st.prdata = {29'h0000_0000, st_ff.ssim_en, 2'b00};
            FDSF_OFS_SIM: nxt_st.prdata = {24'h00_0000, st_ff.sim_dev};
            default: nxt_st.prdata = FDSF_RST_WORD;
         endcase
      end
      if (rd) begin
         nxt_st.prdata = st_ff.prdata;
      end
   end

   // ********************
   // State register
   // ********************
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st_ff <= '0;
         st_ff.dev <= FDSF_RST_DEV;
         st_ff.real_dev <= FDSF_RST_DEV;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign prdata = st_ff.prdata;
   assign pready = st_ff.pready;
   assign pslverr = st_ff.pslverr;
   assign device_status_byte = st_ff.dev;
   assign extended_device_status_byte = st_ff.ext;
   assign diagnostic_status_zero = st_ff.diag0;
   assign diagnostic_status_one = st_ff.diag1;
endmodule // fdsf_top
`default_nettype wire
